// ### src/tmf_pkg.sv
package tmf_pkg;
   // ==========================================================
   // Register map
   localparam logic [5:0] ADDR_RATE_MANTISSA = 6'h11;
   localparam logic [5:0] ADDR_MOD_SYNC      = 6'h12;
   localparam logic [5:0] ADDR_FEC_PREAMBLE  = 6'h13;
   localparam logic [7:0] RST_RATE_MANTISSA  = 8'h22;
   localparam logic [7:0] RST_MOD_SYNC       = 8'h12;
   localparam logic [7:0] RST_FEC_PREAMBLE   = 8'h22;
   localparam logic [7:0] MASK_MOD_SYNC      = 8'h7F;
   localparam logic [7:0] MASK_FEC_PREAMBLE  = 8'hF3;
   localparam int         POS_MODULATION     = 4;
   localparam int         POS_MANCHESTER     = 3;
   localparam int         POS_SYNC_MODE      = 0;
   localparam int         POS_ERROR_CODING   = 7;
   localparam int         POS_PREAMBLE       = 4;
   localparam int         POS_SPACING_EXP    = 0;
   // ==========================================================
   // Framing constants
   localparam logic [1:0] LEN_FIXED          = 2'h0;
   localparam logic [1:0] LEN_INFINITE       = 2'h2;
   localparam logic [7:0] PREAMBLE_PATTERN   = 8'hAA;
   localparam logic [4:0] BYTE_BITS          = 5'h08;
   localparam logic [4:0] WORD_BITS          = 5'h10;
   localparam int         FIFO_DEPTH         = 32;
   localparam int         BYTE_W             = 8;

   typedef struct packed {
      logic [7:0] rate_mantissa;
      logic [2:0] modulation_select;
      logic       manchester_en;
      logic [2:0] sync_mode;
      logic       error_coding_enable;
      logic [2:0] preamble_code;
      logic [1:0] spacing_exponent;
   } tmf_cfg_t;

   typedef enum logic [1:0] {
      ST_IDLE     = 2'b00,
      ST_PREAMBLE = 2'b01,
      ST_SYNC     = 2'b10,
      ST_PAYLOAD  = 2'b11
   } tmf_state_t;

   // ==========================================================
   // Decoding helpers
   function automatic logic [7:0] preamble_bytes(input logic [2:0] code);
      case (code)
         3'h0:    return 8'h02;
         3'h1:    return 8'h03;
         3'h2:    return 8'h04;
         3'h3:    return 8'h06;
         3'h4:    return 8'h08;
         3'h5:    return 8'h0C;
         3'h6:    return 8'h10;
         default: return 8'h18;
      endcase
   endfunction

   function automatic logic sync_disabled(input logic [2:0] mode);
      return mode[1:0] == 2'h0;
   endfunction

   function automatic logic sync_repeated(input logic [2:0] mode);
      return mode[1:0] == 2'h3;
   endfunction

   function automatic logic modulation_defined(input logic [2:0] m);
      return m == 3'h0 || m == 3'h1 || m == 3'h3 || m == 3'h7;
   endfunction

   // Rate one half convolutional code; returns {next state, 16 coded bits}.
   function automatic logic [18:0] fec_encode(input logic [7:0] d, input logic [2:0] st);
      logic [2:0]  s;
      logic [15:0] c;
      s = st;
      c = 16'h0000;
      for (int i = 7; i >= 0; i--) begin
         c[2*i+1] = d[i] ^ s[2] ^ s[1] ^ s[0];
         c[2*i]   = d[i] ^ s[1] ^ s[0];
         s        = {s[1:0], d[i]};
      end
      return {s, c};
   endfunction

   // Four by four block interleaver, read out column by column.
   function automatic logic [15:0] fec_interleave(input logic [15:0] c);
      logic [15:0] r;
      r = 16'h0000;
      for (int j = 0; j < 16; j++) begin
         r[15-j] = c[15-((j % 4) * 4 + j / 4)];
      end
      return r;
   endfunction
endpackage

// ### src/tmf_fifo.sv
module tmf_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // Fill side
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   // Drain side
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   // Depth must be a power of two so the pointers wrap on their own.
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [CW-1:0]    count_reg;
   logic [CW-1:0]    count_next;
   logic             in_ready_reg;
   logic             out_valid_reg;

   wire push = in_valid && in_ready_reg;
   wire pop  = out_valid_reg && out_ready;

   assign count_next = count_reg + CW'(push) - CW'(pop);
   assign out_data   = mem[rd_ptr_reg];
   assign in_ready   = in_ready_reg;
   assign out_valid  = out_valid_reg;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wr_ptr_reg    <= '0;
         rd_ptr_reg    <= '0;
         count_reg     <= '0;
         in_ready_reg  <= 1'b1;
         out_valid_reg <= 1'b0;
      end else begin
         wr_ptr_reg    <= wr_ptr_reg + AW'(push);
         rd_ptr_reg    <= rd_ptr_reg + AW'(pop);
         count_reg     <= count_next;
         in_ready_reg  <= count_next != CW'(DEPTH);
         out_valid_reg <= count_next != '0;
      end
   end
endmodule

// ### src/tmf_framer.sv
module tmf_framer import tmf_pkg::*; (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RESET_N,
   // Register port
   input  wire logic [5:0]  REG_ADDR,
   input  wire logic        REG_WRITE,
   input  wire logic [7:0]  REG_WDATA,
   output logic [7:0]       REG_RDATA,
   // Neighbouring configuration fields
   input  wire logic [3:0]  RATE_EXPONENT,
   input  wire logic [7:0]  SPACING_MANTISSA,
   input  wire logic [7:0]  CHANNEL_NUMBER,
   input  wire logic [1:0]  LENGTH_CONFIG,
   input  wire logic [7:0]  PACKET_LENGTH,
   input  wire logic [15:0] SYNC_WORD,
   // Payload stream
   input  wire logic [7:0]  DATA_IN,
   input  wire logic        DATA_VALID,
   output logic             DATA_READY,
   // Packet control
   input  wire logic        TX_START,
   output logic             TX_BUSY,
   output logic             TX_UNDERFLOW,
   // Modulator side
   output logic             TX_BIT,
   output logic             TX_BIT_STROBE,
   output logic [2:0]       MOD_SELECT,
   output logic             MOD_DEFINED,
   output logic [19:0]      CHANNEL_OFFSET
);
   // ==========================================================
   // Configuration registers
   logic [7:0]  rate_mant_reg;
   logic [7:0]  mod_sync_reg;
   logic [7:0]  fec_pre_reg;
   logic [7:0]  rdata_reg;
   logic [7:0]  rdata_next;
   tmf_cfg_t    cfg;

   wire wr_rate = REG_WRITE && REG_ADDR == ADDR_RATE_MANTISSA;
   wire wr_mod  = REG_WRITE && REG_ADDR == ADDR_MOD_SYNC;
   wire wr_fec  = REG_WRITE && REG_ADDR == ADDR_FEC_PREAMBLE;

   assign rdata_next = (REG_ADDR == ADDR_RATE_MANTISSA) ? rate_mant_reg :
                       (REG_ADDR == ADDR_MOD_SYNC)      ? mod_sync_reg  :
                       (REG_ADDR == ADDR_FEC_PREAMBLE)  ? fec_pre_reg   : 8'h00;

   assign cfg = '{rate_mantissa:       rate_mant_reg,
                  modulation_select:   mod_sync_reg[POS_MODULATION +: 3],
                  manchester_en:       mod_sync_reg[POS_MANCHESTER],
                  sync_mode:           mod_sync_reg[POS_SYNC_MODE +: 3],
                  error_coding_enable: fec_pre_reg[POS_ERROR_CODING],
                  preamble_code:       fec_pre_reg[POS_PREAMBLE +: 3],
                  spacing_exponent:    fec_pre_reg[POS_SPACING_EXP +: 2]};

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         rate_mant_reg <= RST_RATE_MANTISSA;
         mod_sync_reg  <= RST_MOD_SYNC;
         fec_pre_reg   <= RST_FEC_PREAMBLE;
         rdata_reg     <= 8'h00;
      end else begin
         if (wr_rate) rate_mant_reg <= REG_WDATA;
         if (wr_mod) mod_sync_reg <= REG_WDATA & MASK_MOD_SYNC;
         if (wr_fec) fec_pre_reg <= REG_WDATA & MASK_FEC_PREAMBLE;
         rdata_reg <= rdata_next;
      end
   end

   // ==========================================================
   // Symbol rate and channel offset
   logic [27:0] acc_reg;
   logic [23:0] rate_step;
   logic [28:0] rate_sum;
   logic [11:0] spc_step;
   logic [19:0] chan_product;

   assign rate_step    = {15'h0000, 1'b1, cfg.rate_mantissa} << RATE_EXPONENT;
   assign rate_sum     = {1'b0, acc_reg} + {5'h00, rate_step};
   assign spc_step     = {3'h0, 1'b1, SPACING_MANTISSA} << cfg.spacing_exponent;
   assign chan_product = {8'h00, spc_step} * {12'h000, CHANNEL_NUMBER};

   wire rate_tick = rate_sum[28];

   // ==========================================================
   // Payload buffer
   logic [7:0] fifo_data;
   logic       fifo_valid;
   logic       pop;

   tmf_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (CLK),
      .reset_n   (RESET_N),
      .in_data   (DATA_IN),
      .in_valid  (DATA_VALID),
      .in_ready  (DATA_READY),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (pop)
   );

   // ==========================================================
   // Framer
   tmf_state_t  state_reg;
   tmf_state_t  state_next;
   logic [15:0] shift_reg;
   logic [15:0] shift_next;
   logic [4:0]  bits_reg;
   logic [4:0]  bits_next;
   logic [7:0]  cnt_reg;
   logic [7:0]  cnt_next;
   logic [2:0]  fec_st_reg;
   logic [2:0]  fec_st_next;
   logic        first_reg;
   logic        half_reg;
   logic        underflow_reg;
   logic        underflow_next;
   logic        load_req;
   logic        tx_bit_reg;
   logic        strobe_reg;
   logic        busy_reg;
   logic [2:0]  mod_sel_reg;
   logic        mod_def_reg;
   logic [19:0] chan_off_reg;
   logic [18:0] coded;
   logic [15:0] pay_word;

   // Manchester is forced off outside fixed length, so a bad host setting cannot break framing.
   wire manch_on = cfg.manchester_en && LENGTH_CONFIG == LEN_FIXED;
   wire active   = state_reg != ST_IDLE;
   wire bit_done = rate_tick && active && (!manch_on || half_reg);
   wire unit_end = bit_done && bits_reg == 5'h01;
   wire chip     = (manch_on && half_reg) ? ~shift_reg[15] : shift_reg[15];

   assign coded    = fec_encode(fifo_data, first_reg ? 3'h0 : fec_st_reg);
   assign pay_word = cfg.error_coding_enable ? fec_interleave(coded[15:0]) : {fifo_data, 8'h00};

   always_comb begin
      state_next     = state_reg;
      shift_next     = bit_done ? {shift_reg[14:0], 1'b0} : shift_reg;
      bits_next      = bit_done ? bits_reg - 5'h01 : bits_reg;
      cnt_next       = cnt_reg;
      fec_st_next    = fec_st_reg;
      underflow_next = underflow_reg;
      load_req       = 1'b0;
      pop            = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (TX_START) begin
               underflow_next = 1'b0;
               if (sync_disabled(cfg.sync_mode)) begin
                  load_req = 1'b1;
               end else begin
                  state_next = ST_PREAMBLE;
                  shift_next = {PREAMBLE_PATTERN, 8'h00};
                  bits_next  = BYTE_BITS;
                  cnt_next   = preamble_bytes(cfg.preamble_code) - 8'h01;
               end
            end
         end
         ST_PREAMBLE: begin
            if (unit_end && cnt_reg != 8'h00) begin
               shift_next = {PREAMBLE_PATTERN, 8'h00};
               bits_next  = BYTE_BITS;
               cnt_next   = cnt_reg - 8'h01;
            end else if (unit_end) begin
               state_next = ST_SYNC;
               shift_next = SYNC_WORD;
               bits_next  = WORD_BITS;
               cnt_next   = {7'h00, sync_repeated(cfg.sync_mode)};
            end
         end
         ST_SYNC: begin
            if (unit_end && cnt_reg != 8'h00) begin
               shift_next = SYNC_WORD;
               bits_next  = WORD_BITS;
               cnt_next   = cnt_reg - 8'h01;
            end else if (unit_end) begin
               load_req = 1'b1;
            end
         end
         ST_PAYLOAD: begin
            load_req = unit_end;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      if (load_req) begin
         if (!first_reg && LENGTH_CONFIG != LEN_INFINITE && cnt_reg == 8'h00) begin
            state_next = ST_IDLE;
         end else if (!fifo_valid) begin
            state_next     = ST_IDLE;
            underflow_next = LENGTH_CONFIG != LEN_INFINITE;
         end else begin
            pop         = 1'b1;
            state_next  = ST_PAYLOAD;
            shift_next  = pay_word;
            bits_next   = cfg.error_coding_enable ? WORD_BITS : BYTE_BITS;
            fec_st_next = coded[18:16];
            if (!first_reg) begin
               cnt_next = cnt_reg - 8'h01;
            end else if (LENGTH_CONFIG == LEN_FIXED) begin
               cnt_next = PACKET_LENGTH - 8'h01;
            end else begin
               cnt_next = fifo_data;
            end
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         state_reg     <= ST_IDLE;
         shift_reg     <= 16'h0000;
         bits_reg      <= 5'h00;
         cnt_reg       <= 8'h00;
         fec_st_reg    <= 3'h0;
         first_reg     <= 1'b1;
         half_reg      <= 1'b0;
         underflow_reg <= 1'b0;
         acc_reg       <= 28'h0000000;
      end else begin
         state_reg     <= state_next;
         shift_reg     <= shift_next;
         bits_reg      <= bits_next;
         cnt_reg       <= cnt_next;
         fec_st_reg    <= fec_st_next;
         first_reg     <= state_next == ST_IDLE || (first_reg && !pop);
         half_reg      <= active && manch_on && (half_reg ^ rate_tick);
         underflow_reg <= underflow_next;
         acc_reg       <= rate_sum[27:0];
      end
   end

   // ==========================================================
   // Registered outputs
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         tx_bit_reg   <= 1'b0;
         strobe_reg   <= 1'b0;
         busy_reg     <= 1'b0;
         mod_sel_reg  <= 3'h0;
         mod_def_reg  <= 1'b0;
         chan_off_reg <= 20'h00000;
      end else begin
         tx_bit_reg   <= (rate_tick && active) ? chip : tx_bit_reg;
         strobe_reg   <= rate_tick && active;
         busy_reg     <= state_next != ST_IDLE;
         mod_sel_reg  <= cfg.modulation_select;
         mod_def_reg  <= modulation_defined(cfg.modulation_select);
         chan_off_reg <= chan_product;
      end
   end

   assign REG_RDATA      = rdata_reg;
   assign TX_BIT         = tx_bit_reg;
   assign TX_BIT_STROBE  = strobe_reg;
   assign TX_BUSY        = busy_reg;
   assign TX_UNDERFLOW   = underflow_reg;
   assign MOD_SELECT     = mod_sel_reg;
   assign MOD_DEFINED    = mod_def_reg;
   assign CHANNEL_OFFSET = chan_off_reg;

   // ==========================================================
   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   rate_strobe_a: assert property ((rate_tick && active) |=> TX_BIT_STROBE && $past(rate_sum[28]))
      else $error("symbol strobe does not follow rate carry");
   mod_select_a: assert property (wr_mod |-> ##2 MOD_SELECT == $past(REG_WDATA[6:4], 2))
      else $error("modulation select not taken from write");
   manch_chip_a: assert property ((rate_tick && active && manch_on && half_reg) |=> TX_BIT != $past(TX_BIT))
      else $error("second Manchester chip not inverted");
   no_preamble_a: assert property ((state_reg == ST_IDLE && TX_START && sync_disabled(cfg.sync_mode))
      |=> state_reg inside {ST_IDLE, ST_PAYLOAD})
      else $error("preamble or sync sent while disabled");
   sync_count_a: assert property ((state_reg == ST_PREAMBLE && state_next == ST_SYNC)
      |=> bits_reg == WORD_BITS && cnt_reg == {7'h00, $past(sync_repeated(cfg.sync_mode))})
      else $error("sync word length or repeat wrong");
   fec_length_a: assert property (pop |=> bits_reg == ($past(cfg.error_coding_enable) ? 5'h10 : 5'h08))
      else $error("payload unit length wrong for coding setting");
   preamble_count_a: assert property ((state_reg == ST_IDLE && state_next == ST_PREAMBLE)
      |=> cnt_reg == $past(preamble_bytes(cfg.preamble_code)) - 8'h01)
      else $error("preamble byte count wrong");
   chan_offset_a: assert property (##1 CHANNEL_OFFSET
      == 20'($past({1'b1, SPACING_MANTISSA}) * (20'h00001 << $past(cfg.spacing_exponent)) * $past(CHANNEL_NUMBER)))
      else $error("channel offset wrong");
   fixed_length_a: assert property ((state_reg != ST_PAYLOAD && pop && LENGTH_CONFIG == LEN_FIXED)
      |=> cnt_reg == $past(PACKET_LENGTH) - 8'h01)
      else $error("fixed length not loaded");
   reserved_zero_a: assert property (wr_fec |=> fec_pre_reg[3:2] == 2'h0 && $past(REG_WDATA[7:4]) == fec_pre_reg[7:4])
      else $error("reserved bits stored");
endmodule

// ### tb/tmf_host.sv
// ==========================================================
// Host model driving the register port
module tmf_host (
   // Clock
   input  wire logic       clk,
   // Register port
   output logic [5:0]      reg_addr,
   output logic            reg_write,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      reg_addr = 6'h00;
      reg_write = 1'b0;
      reg_wdata = 8'h00;
   end

   // The data lines show the inverse after a write so stale data never looks valid.
   task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(posedge clk);
      #1;
      reg_write = 1'b0;
      reg_wdata = ~d;
      @(posedge clk);
      #1;
   endtask

   // Read data is registered, so it is taken at the second edge after the address.
   task automatic read_reg(input logic [5:0] a, output logic [7:0] d);
      reg_addr = a;
      repeat (2) @(posedge clk);
      d = reg_rdata;
      #1;
   endtask
endmodule

// ### tb/tb.sv
module tb import tmf_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Signals
   logic clk, reset_n, reg_write, data_valid, data_ready, tx_start, tx_busy, tx_underflow;
   logic tx_bit, tx_bit_strobe, mod_defined, ok;
   logic [5:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, spacing_mantissa, channel_number, packet_length, data_in, rd;
   logic [3:0] rate_exponent;
   logic [1:0] length_config;
   logic [15:0] sync_word;
   logic [2:0] mod_select;
   logic [19:0] channel_offset;
   int mismatches, tests_run, cyc, last_cyc, period;
   bit have_last;
   logic exp_q[$];
   logic [7:0] pl[$];
   int pre_tab[8] = '{2, 3, 4, 6, 8, 12, 16, 24};

   tmf_host host_u (.clk(clk), .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
                    .reg_rdata(reg_rdata));
   tmf_framer dut_u (.CLK(clk), .RESET_N(reset_n), .REG_ADDR(reg_addr), .REG_WRITE(reg_write),
      .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .RATE_EXPONENT(rate_exponent),
      .SPACING_MANTISSA(spacing_mantissa), .CHANNEL_NUMBER(channel_number), .LENGTH_CONFIG(length_config),
      .PACKET_LENGTH(packet_length), .SYNC_WORD(sync_word), .DATA_IN(data_in), .DATA_VALID(data_valid),
      .DATA_READY(data_ready), .TX_START(tx_start), .TX_BUSY(tx_busy), .TX_UNDERFLOW(tx_underflow),
      .TX_BIT(tx_bit), .TX_BIT_STROBE(tx_bit_strobe), .MOD_SELECT(mod_select), .MOD_DEFINED(mod_defined),
      .CHANNEL_OFFSET(channel_offset));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ==========================================================
   // Comparison and report
   task automatic chk_val(input logic [19:0] got, input logic [19:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: value %0h, expected %0h", $time, got, exp);
      end
   endtask

   task automatic chk_chip(input logic got);
      logic e;
      tests_run++;
      e = (exp_q.size() == 0) ? ~got : exp_q.pop_front();
      if (got !== e) begin
         mismatches++;
         $display("CHECK FAILED at %0t: chip %b, expected %b", $time, got, e);
      end
   endtask

   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // Chips are checked as they appear; strobe spacing follows the symbol rate.
   always @(posedge clk) begin
      cyc++;
      if (tx_bit_strobe === 1'b1) begin
         chk_chip(tx_bit);
         if (have_last) chk_val(20'(cyc - last_cyc), 20'(period));
         have_last = 1'b1;
         last_cyc = cyc;
      end
   end

   initial begin
      #800000;
      mismatches++;
      $display("CHECK FAILED at %0t: watchdog", $time);
      report_and_stop();
   end

   // ==========================================================
   // Stimulus helpers
   function automatic logic [15:0] code_byte(input logic [7:0] d, inout logic [2:0] s);
      logic [15:0] c, r;
      for (int i = 7; i >= 0; i--) begin
         c[2*i+1] = d[i] ^ s[2] ^ s[1] ^ s[0];
         c[2*i] = d[i] ^ s[1] ^ s[0];
         s = {s[1:0], d[i]};
      end
      for (int j = 0; j < 16; j++) r[15-j] = c[15-((j % 4) * 4 + j / 4)];
      return r;
   endfunction

   task automatic add_bits(input logic [15:0] v, input int n, input bit man);
      for (int i = n - 1; i >= 0; i--) begin
         exp_q.push_back(v[i]);
         if (man) exp_q.push_back(~v[i]);
      end
   endtask

   task automatic push(input logic [7:0] b, output logic acc);
      int n;
      n = 0;
      data_in = b;
      data_valid = 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (data_ready !== 1'b1 && n < 4);
      acc = data_ready;
      #1;
   endtask

   task automatic make_pl(input int n);
      for (int k = 0; k < n; k++) pl.push_back(8'($urandom));
   endtask

   task automatic send(input logic [7:0] mcfg, input logic [7:0] fcfg, input logic [1:0] len,
                       input bit retrig, input bit in_fifo, input int short_by = 0);
      logic [2:0] st;
      bit man;
      int n;
      man = mcfg[3] && len == 2'h0;
      st = 3'h0;
      n = 0;
      host_u.write_reg(6'h12, mcfg);
      host_u.write_reg(6'h13, fcfg);
      length_config = len;
      packet_length = 8'(pl.size() + short_by);
      if (mcfg[1:0] != 2'h0) begin
         for (int i = 0; i < pre_tab[fcfg[6:4]]; i++) add_bits(16'h00AA, 8, man);
         add_bits(sync_word, 16, man);
         if (mcfg[1:0] == 2'h3) add_bits(sync_word, 16, man);
      end
      foreach (pl[i]) begin
         if (fcfg[7]) add_bits(code_byte(pl[i], st), 16, man);
         else add_bits({8'h00, pl[i]}, 8, man);
      end
      if (!in_fifo) foreach (pl[i]) push(pl[i], ok);
      data_valid = 1'b0;
      tx_start = 1'b1;
      have_last = 1'b0;
      @(posedge clk);
      #1 tx_start = 1'b0;
      @(posedge clk);
      #1;
      while (tx_busy !== 1'b0 && n < 20000) begin
         @(posedge clk);
         #1;
         n++;
         if (retrig) tx_start = (n == 50);
      end
      // The last chip is strobed in the cycle in which busy falls, so one more edge lets the monitor take it.
      @(posedge clk);
      #1;
      chk_val(20'(n < 20000), 20'h1);
      chk_val(20'(exp_q.size()), 20'h0);
      chk_val(tx_underflow, 20'(short_by != 0));
      exp_q.delete();
      pl.delete();
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      reset_n = 1'b0;
      rate_exponent = 4'hF;
      spacing_mantissa = 8'h00;
      channel_number = 8'h00;
      length_config = 2'h0;
      packet_length = 8'h00;
      data_in = 8'h00;
      data_valid = 1'b0;
      tx_start = 1'b0;
      mismatches = 0;
      tests_run = 0;
      cyc = 0;
      period = 32;
      void'($urandom(32'h9948C016));
      sync_word = 16'($urandom);
      repeat (20) @(posedge clk);
      #1 reset_n = 1'b1;
      chk_val(data_ready, 20'h1);
      chk_val(tx_busy, 20'h0);
      host_u.read_reg(6'h11, rd); chk_val(rd, 20'h22);
      host_u.read_reg(6'h12, rd); chk_val(rd, 20'h12);
      host_u.read_reg(6'h13, rd); chk_val(rd, 20'h22);
      host_u.write_reg(6'h12, 8'hFF);
      host_u.read_reg(6'h12, rd); chk_val(rd, 20'h7F);
      host_u.write_reg(6'h13, 8'hFF);
      host_u.read_reg(6'h13, rd); chk_val(rd, 20'hF3);
      host_u.write_reg(6'h10, 8'hFF);
      host_u.read_reg(6'h10, rd); chk_val(rd, 20'h00);
      // Mantissa zero with exponent 15 makes the symbol tick exactly every 32 cycles.
      host_u.write_reg(6'h11, 8'h00);
      host_u.read_reg(6'h11, rd); chk_val(rd, 20'h00);
      for (int i = 0; i < 8; i++) begin
         host_u.write_reg(6'h12, {1'b0, 3'(i), 4'h0});
         chk_val(mod_select, 20'(i));
         chk_val(mod_defined, 20'(8'b1000_1011 >> i) & 20'h1);
      end
      for (int e = 0; e < 4; e++) begin
         spacing_mantissa = 8'($urandom);
         channel_number = 8'($urandom);
         host_u.write_reg(6'h13, 8'(e));
         repeat (2) @(posedge clk);
         #1 chk_val(channel_offset, 20'(((256 + spacing_mantissa) << e) * channel_number));
      end
      for (int i = 0; i < 10; i++) begin
         make_pl(1);
         send(8'(i < 8 ? i : i - 6), 8'((i < 8 ? i : (i - 8) * 4) << 4), 2'h0, 1'b0, 1'b0);
      end
      make_pl(2);
      send(8'h08, 8'h00, 2'h0, 1'b1, 1'b0);
      // The host breaks the fixed length condition on purpose here; Manchester must stay off.
      rate_exponent = 4'hE;
      period = 64;
      make_pl(3);
      pl[0] = 8'h02;
      send(8'h08, 8'h00, 2'h1, 1'b0, 1'b0);
      rate_exponent = 4'hF;
      period = 32;
      // A fixed packet one byte longer than the buffer holds must end early and flag underflow.
      make_pl(1);
      send(8'h00, 8'h00, 2'h0, 1'b0, 1'b0, 1);
      make_pl(2);
      send(8'h00, 8'h80, 2'h0, 1'b0, 1'b0);
      make_pl(32);
      foreach (pl[i]) begin
         push(pl[i], ok);
         chk_val(ok, 20'h1);
      end
      push(8'hFF, ok);
      chk_val(ok, 20'h0);
      send(8'h02, 8'h00, 2'h2, 1'b0, 1'b1);
      chk_val(data_ready, 20'h1);
      report_and_stop();
   end
endmodule
